// file: design/tmcr_core.sv
// Purpose: One sixteen-bit counter with four operating modes
// Assumes: Enables come from the front end; each cycle an enable is high is one count step
// Notes: A software write wins over a count step in the same cycle
`timescale 1ns/1ps
module tmcr_core (
    input wire logic clock_in,
    input wire logic rstn_in,
    tmcr_core_if.core bus
);
    logic [7:0] lo_reg; // Low byte of the count
    logic [7:0] lo_next;
    logic [7:0] hi_reg; // High byte of the count
    logic [7:0] hi_next;
    logic ovf_reg; // Overflow pulse
    logic ovf_next;
    logic hovf_reg; // Split high byte overflow pulse
    logic hovf_next;

    // Increment terms and carries
    wire [7:0] lo_inc = lo_reg + 8'h01;
    wire [7:0] hi_inc = hi_reg + 8'h01;
    wire [4:0] lo5_inc = lo_reg[4:0] + 5'h01;
    wire lo_full = (lo_reg == tmcr_pkg::BYTE_ALL_ONES);
    wire hi_full = (hi_reg == tmcr_pkg::BYTE_ALL_ONES);
    wire lo5_full = (lo_reg[4:0] == tmcr_pkg::LOW5_ALL_ONES);

    // Next count from mode, enables and writes
    always_comb begin
        lo_next = lo_reg;
        hi_next = hi_reg;
        ovf_next = 1'b0;
        hovf_next = 1'b0;
        if (bus.cnt_en) begin
            case (bus.mode)
                tmcr_pkg::TMCR_MODE_13BIT: begin
                    // Five low bits carry into the high byte
                    lo_next = {lo_reg[7:5], lo5_inc};
                    if (lo5_full) begin
                        hi_next = hi_inc;
                        ovf_next = hi_full;
                    end
                end
                tmcr_pkg::TMCR_MODE_16BIT: begin
                    lo_next = lo_inc;
                    if (lo_full) begin
                        hi_next = hi_inc;
                        ovf_next = hi_full;
                    end
                end
                tmcr_pkg::TMCR_MODE_8BIT_RELOAD: begin
                    // Low byte reloads from the high byte on wrap
                    lo_next = lo_full ? hi_reg : lo_inc;
                    ovf_next = lo_full;
                end
                default: begin
                    // Split: low byte is a free eight-bit counter
                    lo_next = lo_inc;
                    ovf_next = lo_full;
                end
            endcase
        end
        // Split high byte runs on its own enable
        if (bus.hi_en && bus.mode == tmcr_pkg::TMCR_MODE_SPLIT) begin
            hi_next = hi_inc;
            hovf_next = hi_full;
        end
        // Software access takes priority over counting
        if (bus.wr_lo) begin
            lo_next = bus.wdata;
        end
        if (bus.wr_hi) begin
            hi_next = bus.wdata;
        end
    end

    // Count state
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lo_reg <= tmcr_pkg::COUNT_RESET;
            hi_reg <= tmcr_pkg::COUNT_RESET;
            ovf_reg <= 1'b0;
            hovf_reg <= 1'b0;
        end else begin
            lo_reg <= lo_next;
            hi_reg <= hi_next;
            ovf_reg <= ovf_next;
            hovf_reg <= hovf_next;
        end
    end

    assign bus.lo = lo_reg;
    assign bus.hi = hi_reg;
    assign bus.ovf = ovf_reg;
    assign bus.hi_ovf = hovf_reg;
endmodule

// file: design/tmcr_core_if.sv
// Purpose: Carrier between the register front end and one timer core
// Assumes: Single clock domain, all signals synchronous
// Notes: The ctl side drives enables and writes, the core returns counts
`timescale 1ns/1ps
interface tmcr_core_if;
    logic cnt_en; // Count one step of the low byte
    logic hi_en; // Count one step of the high byte in split mode
    tmcr_pkg::tmcr_mode_t mode; // Operating mode
    logic wr_lo; // Software write to the low byte
    logic wr_hi; // Software write to the high byte
    logic [7:0] wdata; // Write data for either byte
    logic [7:0] lo; // Current low byte
    logic [7:0] hi; // Current high byte
    logic ovf; // Pulse on overflow of the whole counter, or of the low byte in reload and split modes
    logic hi_ovf; // Pulse on high byte overflow in split mode

    modport ctl (
        output cnt_en, hi_en, mode, wr_lo, wr_hi, wdata,
        input lo, hi, ovf, hi_ovf
    );
    modport core (
        input cnt_en, hi_en, mode, wr_lo, wr_hi, wdata,
        output lo, hi, ovf, hi_ovf
    );
endinterface

// file: design/tmcr_pkg.sv
// Purpose: Shared constants for the timer zero/one mode and count block
// Assumes: Byte-wide register port at eight-bit register addresses
// Notes: Registers sit at their printed special-function addresses
package tmcr_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_MODE_SELECT = 8'h89;
    localparam logic [7:0] ADDR_ZERO_LOW = 8'h8a;
    localparam logic [7:0] ADDR_ONE_LOW = 8'h8b;
    localparam logic [7:0] ADDR_ZERO_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_ONE_HIGH = 8'h8d;
    // Run, polarity and prescale bypass bits live here
    localparam logic [7:0] ADDR_AUX_CONTROL = 8'h8f;

    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Mode register field positions
    localparam int ZERO_MODE_LSB = 0;
    localparam int ZERO_CSEL_BIT = 2;
    localparam int ZERO_GATE_BIT = 3;
    localparam int ONE_MODE_LSB = 4;
    localparam int ONE_CSEL_BIT = 6;
    localparam int ONE_GATE_BIT = 7;

    // Auxiliary control field positions
    localparam int AUX_ZERO_RUN_BIT = 0;
    localparam int AUX_ONE_RUN_BIT = 1;
    localparam int AUX_ZERO_POL_BIT = 2;
    localparam int AUX_ONE_POL_BIT = 3;
    localparam int AUX_ZERO_BYP_BIT = 4;
    localparam int AUX_ONE_BYP_BIT = 5;
    // Bits above the used field read as zero
    localparam logic [7:0] AUX_WRITE_MASK = 8'h3f;

    // Internal timebase divider when the prescaler is not bypassed
    localparam int PRESCALE_DIV_DEFAULT = 12;

    // All-ones values of the five-bit low field in thirteen-bit mode and of a whole byte
    localparam logic [4:0] LOW5_ALL_ONES = 5'h1f;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;

    // Operating modes of one timer
    typedef enum logic [1:0] {
        TMCR_MODE_13BIT,
        TMCR_MODE_16BIT,
        TMCR_MODE_8BIT_RELOAD,
        TMCR_MODE_SPLIT
    } tmcr_mode_t;
endpackage

// file: design/tmcr_top.sv
// Purpose: Mode and count registers for timers zero and one
// Assumes: Pins synchronous to clock_in; one-cycle read and write strobes
// Notes: Read data appear in the cycle after the read strobe only
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module tmcr_top #(
    parameter int PRESCALE_DIV = tmcr_pkg::PRESCALE_DIV_DEFAULT
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic timer_zero_count_pin_in,
    input wire logic timer_one_count_pin_in,
    input wire logic ext_irq_zero_input_in,
    input wire logic ext_irq_one_input_in,
    output logic timer_zero_ovf_out,
    output logic timer_zero_high_ovf_out,
    output logic timer_one_ovf_out
);
    localparam int PW = (PRESCALE_DIV > 1) ? $clog2(PRESCALE_DIV) : 1;
    localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE_DIV - 1);
    localparam logic [PW-1:0] PRESC_ZERO = '0;

    logic [7:0] mode_reg; // Timer mode select register
    logic [7:0] aux_reg; // Run, polarity and prescale bypass bits
    logic [7:0] rdata_reg; // Registered read data
    logic [7:0] rdata_next;
    logic [PW-1:0] presc_reg; // Internal timebase divider
    logic pin0_prev_reg; // Previous level of count pin zero
    logic pin1_prev_reg; // Previous level of count pin one

    tmcr_core_if t0_if ();
    tmcr_core_if t1_if ();

    // Address match for a write
    function automatic logic wr_hit(input logic [7:0] a,
                                    input logic [7:0] target);
        wr_hit = (a == target);
    endfunction

    // Write strobes per register
    wire wr_mode = wr_in && wr_hit(addr_in, tmcr_pkg::ADDR_MODE_SELECT);
    wire wr_aux = wr_in && wr_hit(addr_in, tmcr_pkg::ADDR_AUX_CONTROL);
    wire wr_z_lo = wr_in && wr_hit(addr_in, tmcr_pkg::ADDR_ZERO_LOW);
    wire wr_o_lo = wr_in && wr_hit(addr_in, tmcr_pkg::ADDR_ONE_LOW);
    wire wr_z_hi = wr_in && wr_hit(addr_in, tmcr_pkg::ADDR_ZERO_HIGH);
    wire wr_o_hi = wr_in && wr_hit(addr_in, tmcr_pkg::ADDR_ONE_HIGH);

    // Mode register fields
    wire [1:0] z_mode = mode_reg[tmcr_pkg::ZERO_MODE_LSB +: 2];
    wire [1:0] o_mode = mode_reg[tmcr_pkg::ONE_MODE_LSB +: 2];
    wire z_csel = mode_reg[tmcr_pkg::ZERO_CSEL_BIT];
    wire o_csel = mode_reg[tmcr_pkg::ONE_CSEL_BIT];
    wire z_gate = mode_reg[tmcr_pkg::ZERO_GATE_BIT];
    wire o_gate = mode_reg[tmcr_pkg::ONE_GATE_BIT];

    // Auxiliary control fields
    wire z_run = aux_reg[tmcr_pkg::AUX_ZERO_RUN_BIT];
    wire o_run = aux_reg[tmcr_pkg::AUX_ONE_RUN_BIT];
    wire z_pol = aux_reg[tmcr_pkg::AUX_ZERO_POL_BIT];
    wire o_pol = aux_reg[tmcr_pkg::AUX_ONE_POL_BIT];
    wire z_byp = aux_reg[tmcr_pkg::AUX_ZERO_BYP_BIT];
    wire o_byp = aux_reg[tmcr_pkg::AUX_ONE_BYP_BIT];

    // Interrupt pin is active when its level equals the polarity bit
    wire z_irq_act = (ext_irq_zero_input_in == z_pol);
    wire o_irq_act = (ext_irq_one_input_in == o_pol);

    // Run qualified by optional pin gating
    wire z_allow = z_run && (!z_gate || z_irq_act);
    wire o_allow = o_run && (!o_gate || o_irq_act);

    // Falling edges on the external count pins
    wire z_fall = pin0_prev_reg && !timer_zero_count_pin_in;
    wire o_fall = pin1_prev_reg && !timer_one_count_pin_in;

    // Internal timebase: every clock when bypassed, else divided
    wire presc_tick = (presc_reg == PRESC_LAST);
    wire z_tick = z_byp || presc_tick;
    wire o_tick = o_byp || presc_tick;

    // Count source select per timer
    wire z_src = z_csel ? z_fall : z_tick;
    wire o_src = o_csel ? o_fall : o_tick;

    // Timer one stops while it is in the inactive mode
    wire o_active = (o_mode != 2'(tmcr_pkg::TMCR_MODE_SPLIT));
    // Split timer zero high byte borrows timer one's run bit
    wire z_split = (z_mode == 2'(tmcr_pkg::TMCR_MODE_SPLIT));

    // Drive timer zero core
    assign t0_if.cnt_en = z_allow && z_src;
    assign t0_if.hi_en = z_split && o_run && z_tick;
    assign t0_if.mode = tmcr_pkg::tmcr_mode_t'(z_mode);
    assign t0_if.wr_lo = wr_z_lo;
    assign t0_if.wr_hi = wr_z_hi;
    assign t0_if.wdata = wdata_in;

    // Drive timer one core
    assign t1_if.cnt_en = o_active && o_allow && o_src;
    assign t1_if.hi_en = 1'b0;
    assign t1_if.mode = tmcr_pkg::tmcr_mode_t'(o_mode);
    assign t1_if.wr_lo = wr_o_lo;
    assign t1_if.wr_hi = wr_o_hi;
    assign t1_if.wdata = wdata_in;

    // Timer zero counter
    tmcr_core u_timer_zero (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .bus(t0_if.core)
    );

    // Timer one counter
    tmcr_core u_timer_one (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .bus(t1_if.core)
    );

    // Read selection; unmapped addresses read zero
    always_comb begin
        rdata_next = tmcr_pkg::READ_IDLE;
        if (!rd_in) begin
            rdata_next = tmcr_pkg::READ_IDLE;
        end else if (addr_in == tmcr_pkg::ADDR_MODE_SELECT) begin
            rdata_next = mode_reg;
        end else if (addr_in == tmcr_pkg::ADDR_ZERO_LOW) begin
            rdata_next = t0_if.lo;
        end else if (addr_in == tmcr_pkg::ADDR_ONE_LOW) begin
            rdata_next = t1_if.lo;
        end else if (addr_in == tmcr_pkg::ADDR_ZERO_HIGH) begin
            rdata_next = t0_if.hi;
        end else if (addr_in == tmcr_pkg::ADDR_ONE_HIGH) begin
            rdata_next = t1_if.hi;
        end else if (addr_in == tmcr_pkg::ADDR_AUX_CONTROL) begin
            rdata_next = aux_reg;
        end
    end

    // Configuration registers
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_reg <= tmcr_pkg::MODE_RESET;
            aux_reg <= tmcr_pkg::AUX_RESET;
        end else begin
            if (wr_mode) begin
                mode_reg <= wdata_in;
            end
            if (wr_aux) begin
                aux_reg <= wdata_in & tmcr_pkg::AUX_WRITE_MASK;
            end
        end
    end

    // Read data, prescaler and pin history
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_reg <= tmcr_pkg::READ_IDLE;
            presc_reg <= PRESC_ZERO;
            // Low start avoids a false edge right after reset
            pin0_prev_reg <= 1'b0;
            pin1_prev_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            presc_reg <= presc_tick ? PRESC_ZERO : presc_reg + PW'(1);
            pin0_prev_reg <= timer_zero_count_pin_in;
            pin1_prev_reg <= timer_one_count_pin_in;
        end
    end

    assign rdata_out = rdata_reg;
    assign timer_zero_ovf_out = t0_if.ovf;
    assign timer_zero_high_ovf_out = t0_if.hi_ovf;
    assign timer_one_ovf_out = t1_if.ovf;
endmodule

// file: dv/tmcr_assertions.sv
// Purpose: Port checks for the timer mode and count registers
// Assumes: Counts are written only while both timers are stopped
// Notes: Mode and aux registers are shadowed from the write port
`timescale 1ns/1ps
module tmcr_assertions #(
    parameter int PRESCALE_DIV = tmcr_pkg::PRESCALE_DIV_DEFAULT
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic timer_zero_count_pin_in,
    input wire logic timer_one_count_pin_in,
    input wire logic ext_irq_zero_input_in,
    input wire logic ext_irq_one_input_in,
    input wire logic timer_zero_ovf_out,
    input wire logic timer_zero_high_ovf_out,
    input wire logic timer_one_ovf_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    logic [7:0] mode_reg; // Shadow mode register
    logic [7:0] aux_reg; // Shadow aux register
    logic [2:0] quiet_reg; // Cycles since pin zero fell
    wire stopped = (aux_reg[1:0] == 2'b00); // Both timers halted
    wire gated = mode_reg[3] && (ext_irq_zero_input_in != aux_reg[2]);
    // Follow writes and pin zero activity
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_reg <= 8'h00;
            aux_reg <= 8'h00;
            quiet_reg <= 3'h0;
        end else begin
            if (wr_in && addr_in == tmcr_pkg::ADDR_MODE_SELECT) begin
                mode_reg <= wdata_in;
            end
            if (wr_in && addr_in == tmcr_pkg::ADDR_AUX_CONTROL) begin
                aux_reg <= wdata_in;
            end
            if (!mode_reg[2] || $fell(timer_zero_count_pin_in)) begin
                quiet_reg <= 3'h0;
            end else if (quiet_reg != 3'h7) begin
                quiet_reg <= quiet_reg + 3'h1;
            end
        end
    end
    // Write then read of one byte returns the written value
    property wr_rd(a);
        (wr_in && addr_in == a && stopped) ##1 (rd_in && addr_in == a)
            |=> rdata_out == $past(wdata_in, 2);
    endproperty
    AST_ZERO_LOW: assert property (wr_rd(tmcr_pkg::ADDR_ZERO_LOW))
        else $error("timer zero low byte lost its write");
    AST_ONE_LOW: assert property (wr_rd(tmcr_pkg::ADDR_ONE_LOW))
        else $error("timer one low byte lost its write");
    AST_ZERO_HIGH: assert property (wr_rd(tmcr_pkg::ADDR_ZERO_HIGH))
        else $error("timer zero high byte lost its write");
    AST_ONE_HIGH: assert property (wr_rd(tmcr_pkg::ADDR_ONE_HIGH))
        else $error("timer one high byte lost its write");
    AST_READ_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data without a read");
    AST_UNMAPPED: assert property (rd_in && addr_in == 8'h8e |=> !rdata_out)
        else $error("unmapped read not zero");
    AST_RUN_OFF: assert property ((!aux_reg[0])[*4] |-> !timer_zero_ovf_out)
        else $error("timer zero wrapped while stopped");
    AST_GATE_SHUT: assert property (gated[*4] |-> !timer_zero_ovf_out)
        else $error("timer zero wrapped while gated off");
    AST_PIN_QUIET: assert property (quiet_reg > 3'h3 |-> !timer_zero_ovf_out)
        else $error("counter wrapped with no pin edge");
    COV_WR_RD: cover property (wr_in ##1 rd_in);
    COV_OVF: cover property (timer_zero_ovf_out);
    COV_GATED: cover property (gated[*4]);
    COV_SPLIT_OVF: cover property (timer_zero_high_ovf_out);
endmodule
bind tmcr_top tmcr_assertions #(.PRESCALE_DIV(PRESCALE_DIV)) tmcr_assertions_i (
    .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .timer_zero_count_pin_in(timer_zero_count_pin_in),
    .timer_one_count_pin_in(timer_one_count_pin_in),
    .ext_irq_zero_input_in(ext_irq_zero_input_in),
    .ext_irq_one_input_in(ext_irq_one_input_in),
    .timer_zero_ovf_out(timer_zero_ovf_out),
    .timer_zero_high_ovf_out(timer_zero_high_ovf_out),
    .timer_one_ovf_out(timer_one_ovf_out));

// file: dv/tmcr_pin_model.sv
// Purpose: External pulse source on one count pin
// Assumes: Pin rests high; each request gives one falling transition
// Notes: LOW_CYCLES sets a prompt or a slow source
`timescale 1ns/1ps
module tmcr_pin_model #(
    parameter int LOW_CYCLES = 2
) (
    input wire logic clock_in,
    input wire logic pulse_in,
    output logic pin_out
);
    int low_count = 0; // Cycles left with the pin low
    // Hold the pin low for LOW_CYCLES after a request
    always @(posedge clock_in) begin
        if (pulse_in) begin
            low_count <= LOW_CYCLES;
        end else if (low_count > 0) begin
            low_count <= low_count - 1;
        end
    end
    assign pin_out = (low_count == 0);
endmodule

// file: dv/tmcr_tb_top.sv
// Purpose: Register tests of the timer mode and count block
// Assumes: Counts are written only while both timers are stopped
// Notes: Read data are checked in the cycle after the strobe
`timescale 1ns/1ps
module tmcr_tb_top;
    localparam logic [7:0] MS = tmcr_pkg::ADDR_MODE_SELECT;
    localparam logic [7:0] ZL = tmcr_pkg::ADDR_ZERO_LOW;
    localparam logic [7:0] OL = tmcr_pkg::ADDR_ONE_LOW;
    localparam logic [7:0] ZH = tmcr_pkg::ADDR_ZERO_HIGH;
    localparam logic [7:0] OH = tmcr_pkg::ADDR_ONE_HIGH;
    localparam logic [7:0] AX = tmcr_pkg::ADDR_AUX_CONTROL;
    logic [7:0] regs [7] = '{MS, ZL, OL, ZH, OH, AX, 8'h8e};
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [1:0] pulse = 2'b00; // Requests to the pin sources
    logic irq0 = 1'b1; // Gating pin level
    logic [7:0] rdata_out;
    logic pin0;
    logic pin1;
    logic ovf0;
    logic ovf1;
    logic ovfh; // Split high byte overflow of timer zero
    logic pend = 1'b0; // A read awaits its data
    logic [7:0] pend_exp = 8'h00;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int ovf0_seen = 0;
    int ovf1_seen = 0;
    int ovfh_seen = 0;
    always #2.5 clock_in = ~clock_in;
    tmcr_top #(.PRESCALE_DIV(2)) tmcr_top_i (
        .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .timer_zero_count_pin_in(pin0),
        .timer_one_count_pin_in(pin1), .ext_irq_zero_input_in(irq0),
        .ext_irq_one_input_in(irq0), .timer_zero_ovf_out(ovf0),
        .timer_zero_high_ovf_out(ovfh), .timer_one_ovf_out(ovf1));
    tmcr_pin_model #(.LOW_CYCLES(1)) tmcr_pin_model_zero_i (
        .clock_in(clock_in), .pulse_in(pulse[0]), .pin_out(pin0));
    tmcr_pin_model #(.LOW_CYCLES(3)) tmcr_pin_model_one_i (
        .clock_in(clock_in), .pulse_in(pulse[1]), .pin_out(pin1));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // One bus cycle; the read of the cycle before is checked here
    task automatic cyc(input logic w, input logic r, input logic [7:0] a,
            input logic [7:0] d, input logic [7:0] e);
        @(posedge clock_in);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= d;
        @(negedge clock_in);
        if (pend) begin
            check(rdata_out, pend_exp);
        end
        pend = r;
        pend_exp = e;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cyc(1'b0, 1'b1, a, 8'h00, e);
    endtask
    // Ask the pin sources for one falling edge, set the gating level
    task automatic pins(input logic [1:0] m, input logic i);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        @(posedge clock_in);
        pulse <= m;
        irq0 <= i;
        @(posedge clock_in);
        pulse <= 2'b00;
        repeat (6) cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    endtask
    // Count overflow pulses and cut a hang short
    always @(posedge clock_in) begin
        cycles++;
        if (ovf0 === 1'b1) begin
            ovf0_seen++;
        end
        if (ovf1 === 1'b1) begin
            ovf1_seen++;
        end
        if (ovfh === 1'b1) begin
            ovfh_seen++;
        end
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge clock_in);
        rstn_in <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        $display("test reset done");
        wr(ZL, 8'hff);
        rd(ZL, 8'hff);
        wr(ZH, 8'h12);
        rd(ZH, 8'h12);
        wr(OL, 8'hff);
        rd(OL, 8'hff);
        wr(OH, 8'h7f);
        rd(OH, 8'h7f);
        wr(MS, 8'h55);
        rd(MS, 8'h55);
        wr(AX, 8'hff);
        rd(AX, 8'h3f);
        wr(AX, 8'h03);
        $display("test access done");
        pins(2'b11, 1'b1);
        rd(ZL, 8'h00);
        rd(ZH, 8'h13);
        rd(OL, 8'h00);
        rd(OH, 8'h80);
        wr(AX, 8'h00);
        pins(2'b11, 1'b1);
        rd(ZL, 8'h00);
        $display("test counting done");
        wr(MS, 8'h5d);
        wr(AX, 8'h01);
        pins(2'b01, 1'b1);
        rd(ZL, 8'h00);
        pins(2'b01, 1'b0);
        rd(ZL, 8'h01);
        wr(AX, 8'h05);
        pins(2'b01, 1'b0);
        rd(ZL, 8'h01);
        pins(2'b01, 1'b1);
        rd(ZL, 8'h02);
        $display("test gating done");
        wr(AX, 8'h00);
        wr(MS, 8'h55);
        foreach (regs[i]) if (i > 0 && i < 5) wr(regs[i], 8'hff);
        wr(AX, 8'h03);
        pins(2'b11, 1'b1);
        rd(ZH, 8'h00);
        rd(OH, 8'h00);
        check(ovf0_seen[7:0], 8'h01);
        check(ovf1_seen[7:0], 8'h01);
        $display("test overflow done");
        // Thirteen-bit timer zero on every clock: three steps
        wr(AX, 8'h00);
        wr(ZL, 8'hfe);
        wr(ZH, 8'hff);
        wr(MS, 8'h00);
        wr(AX, 8'h11);
        repeat (2) cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        wr(AX, 8'h00);
        rd(ZL, 8'he1);
        rd(ZH, 8'h00);
        $display("test thirteen bit done");
        // Reload timer one on the divided timebase: six clocks, three steps
        wr(OL, 8'hfe);
        wr(OH, 8'hf0);
        wr(MS, 8'h20);
        wr(AX, 8'h02);
        repeat (5) cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        wr(AX, 8'h00);
        rd(OL, 8'hf1);
        rd(OH, 8'hf0);
        $display("test reload done");
        // Split timer zero: high byte runs on timer one's run bit
        wr(ZL, 8'h10);
        wr(ZH, 8'hfe);
        wr(MS, 8'h33);
        wr(AX, 8'h12);
        repeat (2) cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        wr(AX, 8'h00);
        rd(ZL, 8'h10);
        rd(ZH, 8'h01);
        rd(OL, 8'hf1);
        rd(OH, 8'hf0);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        check(ovf0_seen[7:0], 8'h02);
        check(ovf1_seen[7:0], 8'h02);
        check(ovfh_seen[7:0], 8'h01);
        $display("test modes done");
        end_of_test();
    end
endmodule
